// [verilog/adcreg_pkg.sv]
// Purpose: constants for the converter control and status register block
// Assumes: AHB-Lite word registers, 40 MHz system clock
// Notes:   offsets are byte addresses of aligned words
package adcreg_pkg;
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_CFG    = 8'h04;
	localparam logic [7:0] OFF_RES_HI = 8'h08;
	localparam logic [7:0] OFF_RES_LO = 8'h0c;
	localparam logic [7:0] OFF_ISTAT  = 8'h10;
	localparam logic [7:0] OFF_IMASK  = 8'h14;
	// control/status field positions
	localparam int CTRL_START = 7;
	localparam int CTRL_BUSY  = 6;
	localparam int CTRL_PD    = 5;
	localparam int CTRL_JUST  = 4;
	// config field positions
	localparam int CFG_INTREF = 7;
	localparam int CFG_BGEN   = 6;
	localparam int CFG_REFSEL = 4;
	// writable bit masks, unimplemented bits stay zero
	localparam logic [7:0] CTRL_WMASK = 8'hb3;
	localparam logic [7:0] CFG_WMASK  = 8'hd7;
	// reset values: busy=1, power-down=1
	localparam logic [7:0] CTRL_RST   = 8'h60;
	localparam logic [7:0] CFG_RST    = 8'h00;
	localparam logic [2:0] CLK_UNDEF  = 3'h7;
	localparam int         CONV_CLKS  = 16;
endpackage

// [verilog/adcreg_top.sv]
// Purpose: control/status registers of a 12-bit converter, AHB-Lite slave
// Assumes: single clock, synchronous active-high reset, word transfers
// Notes:   one wait-free data phase; reads of the status register clear the interrupt status
//
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
// Functional notes
// - busy flag reads high throughout a running conversion
// - power-down bit at 0 keeps converter powered and running
// - power-down bit at 1 removes bias and stops conversion activity
// - internal-ref select 0 routes external input chosen by two-bit channel field
// - busy flag clears by itself when a conversion finishes
// - justify bit selects result placement; unused bits read zero
// - three-bit clock field divides system clock; code 111 undefined
module adcreg_top #(
	parameter int CONV_CYCLES = adcreg_pkg::CONV_CLKS
) (
	// clock and reset
	input  wire logic        CLK_I,
	input  wire logic        SRST_I,
	// ahb-lite slave
	input  wire logic        HSEL_I,
	input  wire logic [7:0]  HADDR_I,
	input  wire logic [1:0]  HTRANS_I,
	input  wire logic        HWRITE_I,
	input  wire logic [2:0]  HSIZE_I,
	input  wire logic [31:0] HWDATA_I,
	input  wire logic        HREADY_I,
	output logic      [31:0] HRDATA_O,
	output logic             HREADYOUT_O,
	output logic             HRESP_O,
	// converter core
	input  wire logic [11:0] CONV_DATA_I,
	output logic             CONV_POWER_EN_O,
	output logic      [3:0]  INPUT_SEL_O,
	output logic             INTERNAL_REF_SEL_O,
	output logic             BANDGAP_EN_O,
	output logic             REF_SOURCE_SEL_O,
	output logic             CONV_CLK_EN_O,
	// interrupt
	output logic             IRQ_O
);
	import adcreg_pkg::*;

	if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_bad_cycles
		$error("CONV_CYCLES out of range");
	end

	typedef enum logic [1:0] {
		ADCR_IDLE  = 2'b00,
		ADCR_ARMED = 2'b01,
		ADCR_RUN   = 2'b10
	} adcr_state_t;

	logic [7:0]  ctrl_reg, ctrl_next;
	logic [7:0]  cfg_reg, cfg_next;
	logic [11:0] result_reg, result_next;
	logic        istat_reg, istat_next;
	logic        imask_reg, imask_next;
	adcr_state_t st_reg, st_next;
	logic [15:0] cnt_reg, cnt_next;
	logic [5:0]  div_reg, div_next;
	logic        dwr_reg, dwr_next;
	logic        drd_reg, drd_next;
	logic [7:0]  daddr_reg, daddr_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        addr_ok;
	logic [5:0]  div_max;
	logic        tick;
	logic        done;
	logic        start_wr;

	assign addr_ok = HSEL_I && HREADY_I && HTRANS_I[1];

	// converter clock divisor: 1,2,4,8,16,32,64; undefined code holds still
	always_comb begin
		unique case (cfg_reg[2:0])
			3'h0:    div_max = 6'h00;
			3'h1:    div_max = 6'h01;
			3'h2:    div_max = 6'h03;
			3'h3:    div_max = 6'h07;
			3'h4:    div_max = 6'h0f;
			3'h5:    div_max = 6'h1f;
			3'h6:    div_max = 6'h3f;
			default: div_max = 6'h3f;
		endcase
	end
	assign tick = (div_reg == div_max) && (cfg_reg[2:0] != CLK_UNDEF) && !ctrl_reg[CTRL_PD];
	// a restart written in the last tick wins over completion
	assign start_wr = dwr_reg && (daddr_reg == OFF_CTRL) && HWDATA_I[CTRL_START];
	assign done = (st_reg == ADCR_RUN) && tick && !start_wr
		&& (cnt_reg == 16'(CONV_CYCLES - 1));

	always_comb begin
		ctrl_next   = ctrl_reg;
		cfg_next    = cfg_reg;
		result_next = result_reg;
		istat_next  = istat_reg;
		imask_next  = imask_reg;
		st_next     = st_reg;
		cnt_next    = cnt_reg;
		div_next    = (div_reg == div_max) ? 6'h00 : div_reg + 6'h01;
		dwr_next    = addr_ok && HWRITE_I;
		drd_next    = addr_ok && !HWRITE_I;
		daddr_next  = addr_ok ? HADDR_I : daddr_reg;
		rdata_next  = 32'h0;
		if (dwr_reg) begin
			unique case (daddr_reg)
				OFF_CTRL:  ctrl_next = (HWDATA_I[7:0] & CTRL_WMASK)
					| (ctrl_reg & ~CTRL_WMASK);
				OFF_CFG:   cfg_next = HWDATA_I[7:0] & CFG_WMASK;
				OFF_IMASK: imask_next = HWDATA_I[0];
				default:   ;
			endcase
		end
		// start: rising edge resets, falling edge launches
		unique case (st_reg)
			ADCR_IDLE: if (ctrl_next[CTRL_START] && !ctrl_reg[CTRL_START]) begin
				st_next = ADCR_ARMED;
				ctrl_next[CTRL_BUSY] = 1'b1;
			end
			ADCR_ARMED: if (!ctrl_next[CTRL_START]) begin
				st_next  = ADCR_RUN;
				cnt_next = 16'h0;
			end
			ADCR_RUN: begin
				ctrl_next[CTRL_BUSY] = 1'b1;
				if (ctrl_next[CTRL_START]) begin
					st_next = ADCR_ARMED;
				end else if (done) begin
					st_next = ADCR_IDLE;
					ctrl_next[CTRL_BUSY] = 1'b0;
					result_next = CONV_DATA_I;
				end else if (tick) begin
					cnt_next = cnt_reg + 16'h1;
				end
			end
			default: st_next = ADCR_IDLE;
		endcase
		// set wins over read-clear
		if (drd_reg && daddr_reg == OFF_ISTAT)
			istat_next = 1'b0;
		if (done)
			istat_next = 1'b1;
		// read data registered at the address phase from the updated state
		if (addr_ok && !HWRITE_I) begin
			unique case (HADDR_I)
				OFF_CTRL:   rdata_next = {24'h0, ctrl_next};
				OFF_CFG:    rdata_next = {24'h0, cfg_next};
				OFF_RES_HI: rdata_next = {24'h0, ctrl_next[CTRL_JUST] ? {4'h0,
					result_next[11:8]} : result_next[11:4]};
				OFF_RES_LO: rdata_next = {24'h0, ctrl_next[CTRL_JUST] ? result_next[7:0]
					: {result_next[3:0], 4'h0}};
				OFF_ISTAT:  rdata_next = {31'h0, istat_next};
				OFF_IMASK:  rdata_next = {31'h0, imask_next};
				default:    rdata_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			ctrl_reg   <= CTRL_RST;
			cfg_reg    <= CFG_RST;
			result_reg <= 12'h0;
			istat_reg  <= 1'b0;
			imask_reg  <= 1'b0;
			st_reg     <= ADCR_IDLE;
			cnt_reg    <= 16'h0;
			div_reg    <= 6'h00;
			dwr_reg    <= 1'b0;
			drd_reg    <= 1'b0;
			daddr_reg  <= 8'h00;
			rdata_reg  <= 32'h0;
		end else begin
			ctrl_reg   <= ctrl_next;
			cfg_reg    <= cfg_next;
			result_reg <= result_next;
			istat_reg  <= istat_next;
			imask_reg  <= imask_next;
			st_reg     <= st_next;
			cnt_reg    <= cnt_next;
			div_reg    <= div_next;
			dwr_reg    <= dwr_next;
			drd_reg    <= drd_next;
			daddr_reg  <= daddr_next;
			rdata_reg  <= rdata_next;
		end
	end

	assign HRDATA_O           = rdata_reg;
	assign HREADYOUT_O        = 1'b1;
	assign HRESP_O            = 1'b0;
	assign CONV_POWER_EN_O    = !ctrl_reg[CTRL_PD];
	assign CONV_CLK_EN_O      = tick && (st_reg == ADCR_RUN);
	assign INTERNAL_REF_SEL_O = cfg_reg[CFG_INTREF];
	assign INPUT_SEL_O        = cfg_reg[CFG_INTREF] ? 4'h0
		: 4'(4'h1 << ctrl_reg[1:0]);
	assign BANDGAP_EN_O       = cfg_reg[CFG_BGEN];
	assign REF_SOURCE_SEL_O   = cfg_reg[CFG_REFSEL];
	assign IRQ_O              = istat_reg && imask_reg;

	// assertions
	a_busy_in_run: assert property (@(posedge CLK_I) disable iff (SRST_I)
		st_reg == ADCR_RUN |-> ctrl_reg[CTRL_BUSY]) else $error("busy low in run");
	sequence s_start_released;
		st_reg == ADCR_ARMED && !ctrl_next[CTRL_START];
	endsequence
	sequence s_run_from_zero;
		st_reg == ADCR_RUN && ctrl_reg[CTRL_BUSY] && cnt_reg == 16'h0;
	endsequence
	a_start_launch: assert property (@(posedge CLK_I) disable iff (SRST_I)
		s_start_released |=> s_run_from_zero) else $error("start did not launch");
	a_power_on: assert property (@(posedge CLK_I) disable iff (SRST_I)
		!ctrl_reg[CTRL_PD] |-> CONV_POWER_EN_O) else $error("power lost");
	a_power_runs: assert property (@(posedge CLK_I) disable iff (SRST_I)
		!ctrl_reg[CTRL_PD] && st_reg == ADCR_RUN |-> ##[0:128] (CONV_CLK_EN_O
		|| st_reg != ADCR_RUN || ctrl_reg[CTRL_PD] || cfg_reg[2:0] == CLK_UNDEF))
		else $error("no converter clock");
	a_power_off: assert property (@(posedge CLK_I) disable iff (SRST_I)
		ctrl_reg[CTRL_PD] |-> !CONV_POWER_EN_O && !CONV_CLK_EN_O)
		else $error("active while off");
	a_input_route: assert property (@(posedge CLK_I) disable iff (SRST_I)
		!cfg_reg[CFG_INTREF] |-> $onehot(INPUT_SEL_O) && INPUT_SEL_O[ctrl_reg[1:0]])
		else $error("bad route");
	a_busy_clears: assert property (@(posedge CLK_I) disable iff (SRST_I)
		done |=> !ctrl_reg[CTRL_BUSY] && istat_reg) else $error("busy stuck");
	a_just_right: assert property (@(posedge CLK_I) disable iff (SRST_I)
		drd_reg && daddr_reg == OFF_RES_HI && ctrl_reg[CTRL_JUST] |-> HRDATA_O[7:4] == 4'h0)
		else $error("justify bits");
	a_undef_clk: assert property (@(posedge CLK_I) disable iff (SRST_I)
		cfg_reg[2:0] == CLK_UNDEF |-> !tick) else $error("undef clock ticks");
	a_unimpl_zero: assert property (@(posedge CLK_I) disable iff (SRST_I)
		(ctrl_reg[3:2] == 2'h0) && (cfg_reg[5] == 1'b0) && (cfg_reg[3] == 1'b0))
		else $error("unimplemented bit set");
endmodule // adcreg_top

// [verification/adcreg_conv_model.sv]
// Purpose: converter core model feeding results to the register block
// Assumes: result constant while powered
// Notes:   unpowered output toggles so a stale value never matches
`timescale 1ns/100ps
module adcreg_conv_model #(
	parameter logic [11:0] RESULT = 12'habc
) (
	input  wire logic        clk_i,
	input  wire logic        power_en_i,
	input  wire logic        clk_en_i,
	output logic      [11:0] data_o,
	output int               ticks_o
);
	logic [11:0] junk = 12'h5a5;
	initial ticks_o = 0;
	always @(posedge clk_i) begin
		junk <= ~junk;
		if (clk_en_i)
			ticks_o <= ticks_o + 1;
	end
	assign data_o = power_en_i ? RESULT : junk;
endmodule // adcreg_conv_model

// [verification/test_adc_control_status_regs.sv]
// Purpose: self-checking bench for the converter register block
// Assumes: zero-wait slave, conversion length parameter set to 2
// Notes:   table rows first, then reset and conversion cases
`timescale 1ns/100ps
module test_adc_control_status_regs;
	import adcreg_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] w, r; logic [7:0] o;} adcreg_row_t;
	logic        clk = 0;
	logic        srst = 1;
	logic        hwrite = 0;
	logic [7:0]  haddr = 0;
	logic [1:0]  htrans = 0;
	logic [31:0] hwdata = 0, hrdata, rd;
	logic        hready, hresp, pwr, iref, bgen, rsel, cke, irq;
	logic [3:0]  isel;
	logic [11:0] cdata;
	int          err_total = 0, total_checks = 0, cyc = 0, ticks, t0, c0;
	adcreg_row_t rows[10] = '{'{8'h04, 32'hff, 32'hd7, 8'he0}, '{8'h04, 32'h0, 32'h0, 8'h01},
		'{8'h00, 32'h21, 32'h61, 8'h02}, '{8'h00, 32'h22, 32'h62, 8'h04},
		'{8'h00, 32'h23, 32'h63, 8'h08}, '{8'h00, 32'h6c, 32'h60, 8'h01},
		'{8'h18, 32'hff, 32'h0, 8'h01}, '{8'h08, 32'hff, 32'h0, 8'h01},
		'{8'h04, 32'h80, 32'h80, 8'h80}, '{8'h04, 32'h0, 32'h0, 8'h01}};
	always #12.5 clk = ~clk;
	adcreg_top #(.CONV_CYCLES(2)) u_adcreg_top (.CLK_I(clk), .SRST_I(srst), .HSEL_I(1'b1),
		.HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
		.HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
		.HRESP_O(hresp), .CONV_DATA_I(cdata), .CONV_POWER_EN_O(pwr), .INPUT_SEL_O(isel),
		.INTERNAL_REF_SEL_O(iref), .BANDGAP_EN_O(bgen), .REF_SOURCE_SEL_O(rsel),
		.CONV_CLK_EN_O(cke), .IRQ_O(irq));
	adcreg_conv_model u_adcreg_conv_model (.clk_i(clk), .power_en_i(pwr), .clk_en_i(cke),
		.data_o(cdata), .ticks_o(ticks));
	task close_out;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			err_total++;
			close_out();
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task conv(input logic [7:0] cfg, input logic [7:0] pd);
		xfer(1, OFF_CFG, {24'h0, cfg});
		xfer(1, OFF_CTRL, {24'h0, 8'h80 | pd});
		xfer(1, OFF_CTRL, {24'h0, pd});
	endtask
	task wait_done;
		int n;
		n = 0;
		do begin
			xfer(0, OFF_CTRL, 0);
			n++;
		end while (rd[6] !== 1'b0 && n < 300);
		chk("busy clear", 32'h0, {31'h0, rd[6]});
	endtask
	initial begin
		repeat (3) @(posedge clk);
		srst <= 0;
		foreach (rows[i]) begin
			xfer(1, rows[i].a, rows[i].w);
			xfer(0, rows[i].a, 0);
			chk("row read", rows[i].r, rd);
			chk("row resp", 32'h0, {31'h0, hresp});
			chk("row outs", {24'h0, rows[i].o}, {24'h0, iref, bgen, rsel, pwr, isel});
		end
		$display("done table");
		srst <= 1;
		@(posedge clk);
		srst <= 0;
		xfer(0, OFF_CTRL, 0);
		chk("ctrl reset", 32'h60, rd);
		chk("power reset", 32'h0, {31'h0, pwr});
		xfer(1, OFF_IMASK, 1);
		t0 = ticks;
		c0 = cyc;
		conv(8'h06, 8'h00);
		xfer(0, OFF_CTRL, 0);
		chk("busy running", 32'h40, rd);
		chk("power on", 32'h1, {31'h0, pwr});
		wait_done();
		chk("slow divider", 32'h1, {31'h0, (cyc - c0) >= 64});
		chk("tick count", 32'h2, ticks - t0);
		chk("irq set", 32'h1, {31'h0, irq});
		xfer(0, OFF_RES_HI, 0);
		chk("high left", 32'hab, rd);
		xfer(0, OFF_RES_LO, 0);
		chk("low left", 32'hc0, rd);
		xfer(0, OFF_ISTAT, 0);
		chk("status", 32'h1, rd);
		// read-clear lands at the data-phase edge
		@(posedge clk);
		chk("irq clear", 32'h0, {31'h0, irq});
		xfer(1, OFF_CTRL, 32'h10);
		xfer(0, OFF_RES_HI, 0);
		chk("high right", 32'h0a, rd);
		xfer(0, OFF_RES_LO, 0);
		chk("low right", 32'hbc, rd);
		$display("done conversion");
		t0 = ticks;
		conv(8'h00, 8'h20);
		repeat (40) @(posedge clk);
		xfer(0, OFF_CTRL, 0);
		chk("busy held", 32'h60, rd);
		chk("no ticks", 32'h0, ticks - t0);
		xfer(1, OFF_CTRL, 0);
		wait_done();
		$display("done power down");
		close_out();
	end
endmodule // test_adc_control_status_regs
